// [rail_ctrl_pkg.sv]
// Constants and carrier types for the rail switch and second core converter control bank
// Function
// - Charge pump policy 0 keeps the charge pump running always, even with all switches open.
// - Policy 1 starts the pump before the first close, stops it after last open.
// - Bit 6 turns the core external switch controller into an internal switch.
// - Slew field 5:4 caps closing slew: 1, 5, 10 mV/us or unlimited.
// - Pin-selected peripheral switch closes on passive-to-active, opens on active-to-passive.
// - Pin-selected core switch closes on passive-to-active, opens on active-to-passive.
// - Pin select codes: 00 none, 01 pin 1, 10 pin 2, 11 pin 13.
// - Voltage pin select 6:5 ramps to setting A on rise, setting B on fall.
// - Code 00 in enable or voltage select leaves that function to the sequencer.
// - Bit 3 is the sequencer target for enable bit 0; bit 0 switches converter.
// - Pin select 2:1 enables converter on passive-to-active, disables on active-to-passive.
// - Second converter control has no effect while core converters run dual-phase.
package rail_ctrl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] RAIL_SWITCH_CONTROL_IDX = 6'h1F;
	localparam logic [5:0] CORE2_CONVERTER_CONTROL_IDX = 6'h20;
	localparam logic [5:0] RAIL_STATUS_IDX = 6'h30;
	localparam logic [5:0] PIN_POLARITY_IDX = 6'h31;

	// Reset values
	localparam logic [7:0] RAIL_SWITCH_CONTROL_RST = 8'h00;
	localparam logic [7:0] CORE2_CONVERTER_CONTROL_RST = 8'h00;
	localparam logic [2:0] PIN_POLARITY_RST = 3'h7;

	// Field positions of rail_switch_control
	localparam int CHARGE_PUMP_POLICY_BIT = 7;
	localparam int CORE_SWITCH_INTERNAL_BIT = 6;
	localparam int RAIL_SWITCH_SLEW_LSB = 4;
	localparam int PERIPHERAL_PIN_SEL_LSB = 2;
	localparam int CORE_PIN_SEL_LSB = 0;

	// Field positions of core2_converter_control
	localparam int BUCK2_VOLTAGE_PIN_SEL_LSB = 5;
	localparam int BUCK2_SEQUENCER_TARGET_BIT = 3;
	localparam int BUCK2_ENABLE_PIN_SEL_LSB = 1;
	localparam int BUCK2_ON_BIT = 0;

	// Pin select codes
	localparam logic [1:0] PIN_SEL_NONE = 2'h0;
	localparam logic [1:0] PIN_SEL_GP1 = 2'h1;
	localparam logic [1:0] PIN_SEL_GP2 = 2'h2;
	localparam logic [1:0] PIN_SEL_GP13 = 2'h3;

	// Charge pump policy codes
	localparam logic CHARGE_PUMP_STATIC = 1'b0;
	localparam logic CHARGE_PUMP_AUTO = 1'b1;

	// AXI responses
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// Charge pump settle time before a switch may close
	localparam int CLK_PERIOD_PS = 8000;
	localparam int CP_SETTLE_NS = 1000;
	localparam int CP_SETTLE_CYCLES = (CP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Edge events of the three general pins, index 0 pin 1, 1 pin 2, 2 pin 13
	typedef struct packed {
		logic [2:0] rise;
		logic [2:0] fall;
	} pin_events_t;

endpackage

// [pin_edge_detect.sv]
// Pin synchroniser with polarity and passive/active edge detection
`timescale 1ns/1ps
module pin_edge_detect
	import rail_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] pins_raw,
	input wire logic [2:0] active_high,
	output pin_events_t events
);

	typedef struct packed {
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] active;
		logic [1:0] warm;
		pin_events_t ev;
	} edge_state_t;

	edge_state_t s_r;
	edge_state_t s_nxt;
	logic [2:0] act_now;

	// Two stages, then polarity, then edge compare
	always_comb begin
		s_nxt = s_r;
		s_nxt.sync1 = pins_raw;
		s_nxt.sync2 = s_r.sync1;
		act_now = ~(s_r.sync2 ^ active_high);
		s_nxt.active = act_now;
		// Edges held off until both stages carry real pin levels, no false edge after reset
		s_nxt.warm = (s_r.warm == 2'h3) ? s_r.warm : s_r.warm + 2'h1;
		s_nxt.ev.rise = (s_r.warm == 2'h3) ? (act_now & ~s_r.active) : 3'h0;
		s_nxt.ev.fall = (s_r.warm == 2'h3) ? (~act_now & s_r.active) : 3'h0;
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign events = s_r.ev;

endmodule

// [rail_switch_and_core2_buck_ctrl.sv]
// Rail switch and second core converter control registers behind an AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
module rail_switch_and_core2_buck_ctrl
	import rail_ctrl_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int CP_SETTLE = CP_SETTLE_CYCLES
)(
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// General pins 1, 2 and 13, asynchronous
	input wire logic general_pin_1,
	input wire logic general_pin_2,
	input wire logic general_pin_13,
	// Same-clock controls from the sequencer and neighbouring logic
	input wire logic sequencer_apply,
	input wire logic sequencer_voltage_b,
	input wire logic peripheral_switch_sw_close,
	input wire logic core_switch_sw_close,
	input wire logic dual_phase_mode,
	// Power stage controls
	output logic charge_pump_on,
	output logic peripheral_rail_switch_closed,
	output logic core_rail_switch_closed,
	output logic core_switch_internal_select,
	output logic [1:0] rail_switch_slew,
	output logic buck2_on,
	output logic buck2_voltage_b_select
);

	// Elaboration checks
	initial begin
		if (ADDR_W < 8 || ADDR_W > 32) begin
			$error("ADDR_W must lie between 8 and 32");
		end
		if (CP_SETTLE < 1 || CP_SETTLE > 255) begin
			$error("CP_SETTLE must lie between 1 and 255");
		end
	end

	typedef struct packed {
		logic awready;
		logic wready;
		logic aw_full;
		logic [ADDR_W-1:0] aw_addr;
		logic w_full;
		logic [7:0] w_data;
		logic w_lane0;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [7:0] rdata;
		logic [7:0] swc;
		logic [7:0] b2c;
		logic [2:0] polarity;
		logic peri_want;
		logic core_want;
		logic peri_closed;
		logic core_closed;
		logic cp_on;
		logic [7:0] cp_cnt;
		logic volt_b;
		logic b2_on;
	} ctrl_state_t;

	ctrl_state_t s_r;
	ctrl_state_t s_nxt;
	pin_events_t ev;
	logic cp_ready;
	logic peri_rise;
	logic peri_fall;
	logic core_rise;
	logic core_fall;
	logic b2_rise;
	logic b2_fall;
	logic v_rise;
	logic v_fall;
	logic [1:0] peri_sel;
	logic [1:0] core_sel;
	logic [1:0] b2_sel;
	logic [1:0] v_sel;

	// Picks the event of the pin a select code names
	function automatic logic pick_pin(input logic [1:0] sel, input logic [2:0] vec);
		logic r;
		r = 1'b0;
		case (sel)
			PIN_SEL_NONE: r = 1'b0;
			PIN_SEL_GP1: r = vec[0];
			PIN_SEL_GP2: r = vec[1];
			PIN_SEL_GP13: r = vec[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Register index of a byte address
	function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
		logic [5:0] idx;
		idx = 6'h00;
		if (addr[1:0] == 2'h0 && (addr >> 8) == '0) begin
			idx = addr[7:2];
		end else begin
			idx = 6'h3F;
		end
		return idx;
	endfunction

	// Readback of a register index, valid flag in bit 8
	function automatic logic [8:0] read_reg(input logic [5:0] idx, input ctrl_state_t st, input logic dual);
		logic [8:0] r;
		r = 9'h000;
		case (idx)
			RAIL_SWITCH_CONTROL_IDX: r = {1'b1, st.swc};
			CORE2_CONVERTER_CONTROL_IDX: r = {1'b1, st.b2c};
			RAIL_STATUS_IDX: r = {1'b1, 3'h0, dual, st.volt_b, st.cp_on, st.core_closed, st.peri_closed};
			PIN_POLARITY_IDX: r = {1'b1, 5'h00, st.polarity};
			default: r = 9'h000;
		endcase
		return r;
	endfunction

	// Pin synchronisers and edge detection
	pin_edge_detect u_pins (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins_raw({general_pin_13, general_pin_2, general_pin_1}),
		.active_high(s_r.polarity),
		.events(ev)
	);

	// Select decoding of the four pin-controlled functions
	always_comb begin
		peri_sel = s_r.swc[PERIPHERAL_PIN_SEL_LSB +: 2];
		core_sel = s_r.swc[CORE_PIN_SEL_LSB +: 2];
		b2_sel = s_r.b2c[BUCK2_ENABLE_PIN_SEL_LSB +: 2];
		v_sel = s_r.b2c[BUCK2_VOLTAGE_PIN_SEL_LSB +: 2];
		peri_rise = pick_pin(peri_sel, ev.rise);
		peri_fall = pick_pin(peri_sel, ev.fall);
		core_rise = pick_pin(core_sel, ev.rise);
		core_fall = pick_pin(core_sel, ev.fall);
		b2_rise = pick_pin(b2_sel, ev.rise);
		b2_fall = pick_pin(b2_sel, ev.fall);
		v_rise = pick_pin(v_sel, ev.rise);
		v_fall = pick_pin(v_sel, ev.fall);
		cp_ready = s_r.cp_on && (s_r.cp_cnt == 8'(CP_SETTLE));
	end

	// Next state of bus slave and control
	always_comb begin
		logic [8:0] rd;
		logic [5:0] widx;
		rd = 9'h000;
		widx = 6'h00;
		s_nxt = s_r;

		// Read channel, answer one cycle after address taken
		if (s_r.arready && s_axi_arvalid) begin
			rd = read_reg(reg_index(s_axi_araddr), s_r, dual_phase_mode);
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = rd[7:0];
			s_nxt.rresp = rd[8] ? AXI_OKAY : AXI_SLVERR;
		end else if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// Write address and data taken in either order
		if (s_r.awready && s_axi_awvalid) begin
			s_nxt.awready = 1'b0;
			s_nxt.aw_full = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_r.wready && s_axi_wvalid) begin
			s_nxt.wready = 1'b0;
			s_nxt.w_full = 1'b1;
			s_nxt.w_data = s_axi_wdata[7:0];
			s_nxt.w_lane0 = s_axi_wstrb[0];
		end

		// Perform the write once both halves are held
		if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
			widx = reg_index(s_r.aw_addr);
			s_nxt.aw_full = 1'b0;
			s_nxt.w_full = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = AXI_OKAY;
			case (widx)
				RAIL_SWITCH_CONTROL_IDX: begin
					if (s_r.w_lane0) begin
						s_nxt.swc = s_r.w_data;
					end
				end
				CORE2_CONVERTER_CONTROL_IDX: begin
					if (s_r.w_lane0) begin
						s_nxt.b2c = s_r.w_data;
					end
				end
				PIN_POLARITY_IDX: begin
					if (s_r.w_lane0) begin
						s_nxt.polarity = s_r.w_data[2:0];
					end
				end
				RAIL_STATUS_IDX: s_nxt.bresp = AXI_OKAY;
				default: s_nxt.bresp = AXI_SLVERR;
			endcase
		end else if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end

		// Peripheral switch request: pin edges or software level
		if (peri_sel != PIN_SEL_NONE) begin
			if (peri_rise) begin
				s_nxt.peri_want = 1'b1;
			end else if (peri_fall) begin
				s_nxt.peri_want = 1'b0;
			end
		end else begin
			s_nxt.peri_want = peripheral_switch_sw_close;
		end

		// Core switch request: pin edges or software level
		if (core_sel != PIN_SEL_NONE) begin
			if (core_rise) begin
				s_nxt.core_want = 1'b1;
			end else if (core_fall) begin
				s_nxt.core_want = 1'b0;
			end
		end else begin
			s_nxt.core_want = core_switch_sw_close;
		end

		// Charge pump policy
		if (s_r.swc[CHARGE_PUMP_POLICY_BIT] == CHARGE_PUMP_STATIC) begin
			s_nxt.cp_on = 1'b1;
		end else if (s_r.peri_want || s_r.core_want) begin
			s_nxt.cp_on = 1'b1;
		end else if (!s_r.peri_closed && !s_r.core_closed) begin
			s_nxt.cp_on = 1'b0;
		end

		// Settle counter, restarts whenever the pump stops
		if (!s_r.cp_on) begin
			s_nxt.cp_cnt = 8'h00;
		end else if (s_r.cp_cnt != 8'(CP_SETTLE)) begin
			s_nxt.cp_cnt = s_r.cp_cnt + 8'h01;
		end

		// Switches close only on a settled pump, open at once
		s_nxt.peri_closed = s_r.peri_want && (s_r.peri_closed || cp_ready);
		s_nxt.core_closed = s_r.core_want && (s_r.core_closed || cp_ready);

		// Second core converter, frozen in dual-phase mode
		if (!dual_phase_mode) begin
			if (b2_sel != PIN_SEL_NONE) begin
				if (b2_rise) begin
					s_nxt.b2c[BUCK2_ON_BIT] = 1'b1;
				end else if (b2_fall) begin
					s_nxt.b2c[BUCK2_ON_BIT] = 1'b0;
				end
			end else if (sequencer_apply) begin
				s_nxt.b2c[BUCK2_ON_BIT] = s_r.b2c[BUCK2_SEQUENCER_TARGET_BIT];
			end
			if (v_sel != PIN_SEL_NONE) begin
				if (v_rise) begin
					s_nxt.volt_b = 1'b0;
				end else if (v_fall) begin
					s_nxt.volt_b = 1'b1;
				end
			end else if (sequencer_apply) begin
				s_nxt.volt_b = sequencer_voltage_b;
			end
			// Enable follows the register only outside dual-phase, writes included
			s_nxt.b2_on = s_nxt.b2c[BUCK2_ON_BIT];
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
			s_r.swc <= RAIL_SWITCH_CONTROL_RST;
			s_r.b2c <= CORE2_CONVERTER_CONTROL_RST;
			s_r.polarity <= PIN_POLARITY_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Bus outputs straight from state
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rdata = {24'h000000, s_r.rdata};

	// Power stage outputs straight from state
	assign charge_pump_on = s_r.cp_on;
	assign peripheral_rail_switch_closed = s_r.peri_closed;
	assign core_rail_switch_closed = s_r.core_closed;
	assign core_switch_internal_select = s_r.swc[CORE_SWITCH_INTERNAL_BIT];
	assign rail_switch_slew = s_r.swc[RAIL_SWITCH_SLEW_LSB +: 2];
	assign buck2_on = s_r.b2_on;
	assign buck2_voltage_b_select = s_r.volt_b;

endmodule

// [rail_ctrl_monitor.sv]
// Port-level checks for the rail switch and second converter control bank
`timescale 1ns/1ps
module rail_ctrl_monitor (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic dual_phase_mode,
	input wire logic charge_pump_on,
	input wire logic peripheral_rail_switch_closed,
	input wire logic core_rail_switch_closed,
	input wire logic core_switch_internal_select,
	input wire logic [1:0] rail_switch_slew,
	input wire logic buck2_on,
	input wire logic buck2_voltage_b_select
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Steps of a register write
	sequence w_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence w_done;
		$rose(s_axi_bvalid);
	endsequence

	// Bus answers within the stated latency
	write_resp_a: assert property (w_taken |-> ##[1:2] w_done) else $error("write response late");
	read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
	// Stored fields move only with a completed write
	slew_write_a: assert property ($changed(rail_switch_slew) |-> w_done) else $error("slew moved");
	internal_write_a: assert property ($changed(core_switch_internal_select) |-> w_done) else $error("internal moved");
	// Pump ordering around the switches
	pump_peri_a: assert property ($rose(peripheral_rail_switch_closed) |-> $past(charge_pump_on)) else $error("peri closed cold");
	pump_core_a: assert property ($rose(core_rail_switch_closed) |-> $past(charge_pump_on)) else $error("core closed cold");
	pump_covers_a: assert property (peripheral_rail_switch_closed || core_rail_switch_closed |-> charge_pump_on)
		else $error("switch closed without pump");
	pump_off_last_a: assert property ($fell(charge_pump_on) |-> !$past(peripheral_rail_switch_closed)
		&& !$past(core_rail_switch_closed)) else $error("pump dropped early");
	// Dual-phase mode freezes the voltage choice and the enable
	dual_freeze_a: assert property ($past(dual_phase_mode) && dual_phase_mode |-> $stable(buck2_voltage_b_select))
		else $error("voltage moved in dual phase");
	dual_on_freeze_a: assert property ($past(dual_phase_mode) && dual_phase_mode |-> $stable(buck2_on))
		else $error("enable moved in dual phase");
endmodule

bind rail_switch_and_core2_buck_ctrl rail_ctrl_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .dual_phase_mode,
	.charge_pump_on, .peripheral_rail_switch_closed, .core_rail_switch_closed, .core_switch_internal_select,
	.rail_switch_slew, .buck2_on, .buck2_voltage_b_select);

// [tb.sv]
// Self-checking bench for the rail switch and second converter control bank
`timescale 1ns/1ps
module tb;
	import rail_ctrl_pkg::*;
	localparam int CPS = 4;
	localparam int LAT = CPS + 12;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic sequencer_apply, sequencer_voltage_b, dual_phase_mode, charge_pump_on, peripheral_rail_switch_closed;
	logic core_rail_switch_closed, core_switch_internal_select, buck2_on, buck2_voltage_b_select;
	logic [7:0] s_axi_awaddr, s_axi_araddr, v;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rail_switch_slew, r, c;
	logic [2:0] gp;
	int failures, comparisons;

	rail_switch_and_core2_buck_ctrl #(.CP_SETTLE(CPS)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .general_pin_1(gp[0]), .general_pin_2(gp[1]),
		.general_pin_13(gp[2]), .sequencer_apply, .sequencer_voltage_b, .peripheral_switch_sw_close(1'b0),
		.core_switch_sw_close(1'b0), .dual_phase_mode, .charge_pump_on, .peripheral_rail_switch_closed,
		.core_rail_switch_closed, .core_switch_internal_select, .rail_switch_slew, .buck2_on, .buck2_voltage_b_select);

	// Free-running 125 MHz clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Xorshift source with a fixed start
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Pins raised for a select code; code none raises all three
	function logic [2:0] pmask(input logic [1:0] code);
		return (code == PIN_SEL_NONE) ? 3'h7 : 3'h1 << (code - 2'h1);
	endfunction

	task chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %0t got %0h expected %0h", $time, g, e);
		end
	endtask

	// Write with address and data offered together
	task wr(input logic [7:0] a, input logic [7:0] dat, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, dat};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 100);
		chk(s_axi_bvalid, 1'b1);
		chk(s_axi_bresp, er);
	endtask

	task rd(input logic [7:0] a);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 100);
		chk(s_axi_rvalid, 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task final_report;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (6000) @(posedge aclk);
		failures++;
		final_report;
	end

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{sequencer_apply, sequencer_voltage_b, dual_phase_mode, gp, s_axi_awaddr, s_axi_araddr} = '0;
		s_axi_wdata = '0;
		s_axi_wstrb = 4'hF;
		seed = 32'h2424;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(charge_pump_on, 1'b1);
		rd(8'h7C);
		chk(d, 32'h0);
		rd(8'h80);
		chk(d, 32'h0);
		// Random contents with pins idle
		repeat (8) begin
			v = 8'(rnd());
			wr(8'h7C, v, AXI_OKAY);
			rd(8'h7C);
			chk(d, {24'h0, v});
			chk(rail_switch_slew, v[5:4]);
			chk(core_switch_internal_select, v[6]);
			v = 8'(rnd());
			wr(8'h80, v, AXI_OKAY);
			rd(8'h80);
			chk(d, {24'h0, v});
			chk(buck2_on, v[0]);
		end
		// Unmapped place
		wr(8'h10, 8'hFF, AXI_SLVERR);
		rd(8'h10);
		chk(r, AXI_SLVERR);
		// Every select code on both switches under the auto pump
		for (int k = 0; k < 2; k++) begin
			for (int i = 0; i < 4; i++) begin
				c = i[1:0];
				wr(8'h7C, 8'h80 | (k ? {6'h0, c} : {4'h0, c, 2'h0}), AXI_OKAY);
				gp <= pmask(c);
				repeat (LAT) @(posedge aclk);
				chk(k ? core_rail_switch_closed : peripheral_rail_switch_closed, c != 2'h0);
				chk(charge_pump_on, c != 2'h0);
				gp <= 3'h0;
				repeat (LAT) @(posedge aclk);
				chk(k ? core_rail_switch_closed : peripheral_rail_switch_closed, 1'b0);
				chk(charge_pump_on, 1'b0);
			end
		end
		// Static pump with all switches open
		wr(8'h7C, 8'h00, AXI_OKAY);
		repeat (4) @(posedge aclk);
		chk(charge_pump_on, 1'b1);
		rd(8'hC0);
		chk(d & 32'hF7, 32'h4);
		// Enable and voltage under one pin
		c = 2'(rnd() % 3 + 1);
		wr(8'h80, {1'b0, c, 2'h0, c, 1'b0}, AXI_OKAY);
		gp <= pmask(c);
		repeat (LAT) @(posedge aclk);
		chk(buck2_on, 1'b1);
		chk(buck2_voltage_b_select, 1'b0);
		gp <= 3'h0;
		repeat (LAT) @(posedge aclk);
		chk(buck2_on, 1'b0);
		chk(buck2_voltage_b_select, 1'b1);
		gp <= pmask(c);
		repeat (LAT) @(posedge aclk);
		chk(buck2_voltage_b_select, 1'b0);
		chk(buck2_on, 1'b1);
		// Sequencer owns both functions on code none
		wr(8'h80, 8'h08, AXI_OKAY);
		sequencer_voltage_b <= 1'b1;
		sequencer_apply <= 1'b1;
		@(posedge aclk);
		sequencer_apply <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(buck2_on, 1'b1);
		chk(buck2_voltage_b_select, 1'b1);
		// Dual phase ignores pins, sequencer and a written enable
		dual_phase_mode <= 1'b1;
		wr(8'h80, {5'h0, c, 1'b0}, AXI_OKAY);
		gp <= 3'h0;
		sequencer_voltage_b <= 1'b0;
		sequencer_apply <= 1'b1;
		@(posedge aclk);
		sequencer_apply <= 1'b0;
		repeat (LAT) @(posedge aclk);
		gp <= pmask(c);
		repeat (LAT) @(posedge aclk);
		chk(buck2_on, 1'b1);
		chk(buck2_voltage_b_select, 1'b1);
		dual_phase_mode <= 1'b0;
		repeat (3) @(posedge aclk);
		chk(buck2_on, 1'b0);
		final_report;
	end
endmodule
